/* shared/window_pkg.sv */
// ============================================================
// window detector shared definitions
package window_pkg;

  // ============================================================
  // register addresses on the special function register bus
  localparam logic [7:0] ADDR_UPPER_LOW = 8'hC3;
  localparam logic [7:0] ADDR_UPPER_HIGH = 8'hC4;
  localparam logic [7:0] ADDR_LOWER_LOW = 8'hC5;
  localparam logic [7:0] ADDR_LOWER_HIGH = 8'hC6;
  localparam logic [7:0] ADDR_WORD_LOW = 8'hBD;
  localparam logic [7:0] ADDR_WORD_HIGH = 8'hBE;
  localparam logic [7:0] ADDR_CONTROL = 8'hE8;

  // ============================================================
  // field positions and reset values
  localparam int FLAG_BIT = 3;
  localparam logic [7:0] RST_UPPER_HIGH = 8'hFF;
  localparam logic [7:0] RST_UPPER_LOW = 8'hFF;
  localparam logic [7:0] RST_LOWER_HIGH = 8'h00;
  localparam logic [7:0] RST_LOWER_LOW = 8'h00;
  localparam logic [7:0] RST_WORD = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;
  localparam logic [4:0] NEG_GROUND = 5'h1F;
  localparam int WORD_W = 10;
  localparam int PAD_W = 6;

  // ============================================================
  // conversion spacing: least time of ten sar clocks at the fastest sar clock
  localparam int CORE_CLK_KHZ = 20000;
  localparam int SAR_CLK_MAX_KHZ = 3000;
  localparam int CONV_MIN_SAR_CLKS = 10;
  localparam int CONV_MIN_CYCLES =
    (CONV_MIN_SAR_CLKS * CORE_CLK_KHZ + SAR_CLK_MAX_KHZ - 1) / SAR_CLK_MAX_KHZ;
  localparam int GAP_W = 7;
  localparam logic [GAP_W-1:0] GAP_ZERO = 7'h00;
  localparam logic [GAP_W-1:0] GAP_ONE = 7'h01;

  // ============================================================
  // carriers
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } sfr_req_s;

  typedef struct packed {
    logic done;
    logic [WORD_W-1:0] word;
  } conv_in_s;

  typedef struct packed {
    logic [7:0] upper_high;
    logic [7:0] upper_low;
    logic [7:0] lower_high;
    logic [7:0] lower_low;
    logic [7:0] word_high;
    logic [7:0] word_low;
    logic flag;
    logic [GAP_W-1:0] gap;
    logic [7:0] rdata;
  } win_state_s;

endpackage

/* logic/window_compare.sv */
`timescale 1ns/1ps
// ============================================================
// window comparison on justified 16-bit words
module window_compare
(
  // operands
  input wire logic [15:0] data,
  input wire logic [15:0] upper,
  input wire logic [15:0] lower,
  input wire logic signed_mode,
  // result
  output logic inside_mode,
  output logic match
);

  // one ordering test serves limit ordering and both bounds
  function automatic logic less_than(input logic [15:0] a, input logic [15:0] b,
                                     input logic sgn);
    less_than = sgn ? ($signed(a) < $signed(b)) : (a < b);
  endfunction

  // lower above upper means inside window, otherwise outside
  always_comb
  begin
    inside_mode = less_than(upper, lower, signed_mode);
    if (inside_mode)
    begin
      match = less_than(upper, data, signed_mode) && less_than(data, lower, signed_mode);
    end
    else
    begin
      match = less_than(data, lower, signed_mode) || less_than(upper, data, signed_mode);
    end
  end

endmodule // window_compare

/* logic/window_detector.sv */
`timescale 1ns/1ps
// ============================================================
module window_detector
#(
  parameter int MIN_SPACING = window_pkg::CONV_MIN_CYCLES
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // register bus
  input wire window_pkg::sfr_req_s sfr_req,
  output logic [7:0] sfr_rdata,
  // converter result and configuration
  input wire window_pkg::conv_in_s conv_in,
  input wire logic justify_select,
  input wire logic [4:0] negative_input_select,
  // status out
  output logic window_match_flag,
  output logic conv_refused
);

  // ============================================================
  // state
  window_pkg::win_state_s st_q;
  window_pkg::win_state_s st_d;
  logic [15:0] data16;
  logic [15:0] upper16;
  logic [15:0] lower16;
  logic diff_mode;
  logic accept;
  logic match;
  logic inside_mode;
  logic ctrl_wr;

  // ============================================================
  // input formatting and comparison
  // mode follows the negative input choice
  assign diff_mode = (negative_input_select != window_pkg::NEG_GROUND);
  assign upper16 = {st_q.upper_high, st_q.upper_low};
  assign lower16 = {st_q.lower_high, st_q.lower_low};

  // sign bits fill the top only for differential data, since single-ended codes are unsigned
  always_comb
  begin
    if (justify_select)
    begin
      data16 = {conv_in.word, {window_pkg::PAD_W{1'b0}}};
    end
    else if (diff_mode)
    begin
      data16 = {{window_pkg::PAD_W{conv_in.word[window_pkg::WORD_W-1]}}, conv_in.word};
    end
    else
    begin
      data16 = {{window_pkg::PAD_W{1'b0}}, conv_in.word};
    end
  end

  // the comparator sees the justified word and justified limits alike
  window_compare u_cmp
  (
    .data(data16),
    .upper(upper16),
    .lower(lower16),
    .signed_mode(diff_mode),
    .inside_mode(inside_mode),
    .match(match)
  );

  // results arriving closer than the conversion time are refused
  assign accept = conv_in.done && (st_q.gap == window_pkg::GAP_ZERO);
  assign ctrl_wr = sfr_req.wr && (sfr_req.addr == window_pkg::ADDR_CONTROL);

  // ============================================================
  // next state
  always_comb
  begin
    st_d = st_q;
    // spacing counter
    if (accept)
    begin
      st_d.gap = MIN_SPACING[window_pkg::GAP_W-1:0] - window_pkg::GAP_ONE;
    end
    else if (st_q.gap != window_pkg::GAP_ZERO)
    begin
      st_d.gap = st_q.gap - window_pkg::GAP_ONE;
    end
    // register writes
    if (sfr_req.wr)
    begin
      unique case (sfr_req.addr)
        window_pkg::ADDR_UPPER_HIGH: st_d.upper_high = sfr_req.wdata;
        window_pkg::ADDR_UPPER_LOW: st_d.upper_low = sfr_req.wdata;
        window_pkg::ADDR_LOWER_HIGH: st_d.lower_high = sfr_req.wdata;
        window_pkg::ADDR_LOWER_LOW: st_d.lower_low = sfr_req.wdata;
        window_pkg::ADDR_CONTROL: st_d.flag = sfr_req.wdata[window_pkg::FLAG_BIT];
        default: st_d.flag = st_q.flag;
      endcase
    end
    // result write and comparison on one edge; a match beats a clear
    if (accept)
    begin
      st_d.word_high = data16[15:8];
      st_d.word_low = data16[7:0];
      if (match)
      begin
        st_d.flag = 1'b1;
      end
    end
    // registered read data, unmapped addresses read zero
    if (sfr_req.rd)
    begin
      unique case (sfr_req.addr)
        window_pkg::ADDR_UPPER_HIGH: st_d.rdata = st_q.upper_high;
        window_pkg::ADDR_UPPER_LOW: st_d.rdata = st_q.upper_low;
        window_pkg::ADDR_LOWER_HIGH: st_d.rdata = st_q.lower_high;
        window_pkg::ADDR_LOWER_LOW: st_d.rdata = st_q.lower_low;
        window_pkg::ADDR_WORD_HIGH: st_d.rdata = st_q.word_high;
        window_pkg::ADDR_WORD_LOW: st_d.rdata = st_q.word_low;
        window_pkg::ADDR_CONTROL:
        begin
          st_d.rdata = window_pkg::READ_ZERO;
          st_d.rdata[window_pkg::FLAG_BIT] = st_q.flag;
        end
        default: st_d.rdata = window_pkg::READ_ZERO;
      endcase
    end
  end

  // ============================================================
  // state register
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      st_q.upper_high <= window_pkg::RST_UPPER_HIGH;
      st_q.upper_low <= window_pkg::RST_UPPER_LOW;
      st_q.lower_high <= window_pkg::RST_LOWER_HIGH;
      st_q.lower_low <= window_pkg::RST_LOWER_LOW;
      st_q.word_high <= window_pkg::RST_WORD;
      st_q.word_low <= window_pkg::RST_WORD;
      st_q.flag <= 1'b0;
      st_q.gap <= window_pkg::GAP_ZERO;
      st_q.rdata <= window_pkg::READ_ZERO;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // flag doubles as the request line toward the interrupt logic
  assign window_match_flag = st_q.flag;
  assign sfr_rdata = st_q.rdata;
  assign conv_refused = conv_in.done && !accept;

  // ============================================================
  // checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_take;
    accept;
  endsequence

  sequence s_quiet;
    (!accept) [*8];
  endsequence

  a_match_sets_flag:
    assert property (accept && match |=> window_match_flag)
    else $error("match did not set the flag");

  a_flag_stays_set:
    assert property (window_match_flag && !(ctrl_wr && !sfr_req.wdata[window_pkg::FLAG_BIT])
                     |=> window_match_flag)
    else $error("flag dropped without a clear");

  a_inside_strict:
    assert property (accept && !diff_mode && (upper16 < lower16) && !window_match_flag
                     && !ctrl_wr && !((data16 > upper16) && (data16 < lower16))
                     |=> !window_match_flag)
    else $error("inside window flagged a word on or beyond a limit");

  a_outside_hits:
    assert property (accept && !diff_mode && !(upper16 < lower16)
                     && ((data16 < lower16) || (data16 > upper16)) |=> window_match_flag)
    else $error("outside window missed a word beyond a limit");

  a_unsigned_order:
    assert property (accept && !diff_mode && (upper16 < lower16)
                     && (data16 > upper16) && (data16 < lower16) |=> window_match_flag)
    else $error("single-ended compare not unsigned");

  a_signed_minus_one:
    assert property (accept && diff_mode && (upper16 == 16'hFFFF) && (data16 == 16'h0000)
                     && ($signed(lower16) > $signed(16'h0000)) |=> window_match_flag)
    else $error("differential compare not signed");

  a_reset_upper_high:
    assert property (@(posedge core_clk) disable iff (1'b0)
                     $past(sys_rst) |-> (st_q.upper_high == window_pkg::RST_UPPER_HIGH))
    else $error("upper limit high byte not all ones after reset");

  a_reset_lower_high:
    assert property (@(posedge core_clk) disable iff (1'b0)
                     $past(sys_rst) |-> (st_q.lower_high == window_pkg::RST_LOWER_HIGH))
    else $error("lower limit high byte not zero after reset");

  a_lower_low_write:
    assert property (sfr_req.wr && (sfr_req.addr == window_pkg::ADDR_LOWER_LOW)
                     |=> st_q.lower_low == $past(sfr_req.wdata))
    else $error("lower limit low byte write lost");

  a_spacing_quiet:
    assert property (s_take |=> s_quiet)
    else $error("comparisons closer than the conversion time");

  a_left_justify:
    assert property (accept && justify_select
                     |=> (st_q.word_low[5:0] == 6'h00)
                     && ({st_q.word_high, st_q.word_low[7:6]} == $past(conv_in.word)))
    else $error("left-justified word wrong");

  a_ground_single:
    assert property (accept && !justify_select && (negative_input_select == window_pkg::NEG_GROUND)
                     |=> st_q.word_high[7:2] == 6'h00)
    else $error("single-ended word carries sign bits");

  a_flag_readable:
    assert property (sfr_req.rd && (sfr_req.addr == window_pkg::ADDR_CONTROL)
                     |=> sfr_rdata[window_pkg::FLAG_BIT] == $past(window_match_flag))
    else $error("flag not visible on read");

  // ============================================================
  // further checks: window choice, signed windows, clearing and refusal
  // a clear only counts when no match lands in the same cycle, since the set wins
  sequence s_clear;
    ctrl_wr && !sfr_req.wdata[window_pkg::FLAG_BIT];
  endsequence

  sequence s_no_hit;
    !(accept && match);
  endsequence

  a_clear_drops_flag:
    assert property (s_clear ##0 s_no_hit |=> !window_match_flag)
    else $error("software clear did not drop the flag");

  // the window meaning is read back from the comparator and held against the limit order
  a_mode_inside_order:
    assert property (!diff_mode && (upper16 < lower16) |-> inside_mode)
    else $error("ordered limits did not select the inside window");

  a_mode_outside_order:
    assert property (diff_mode && !($signed(upper16) < $signed(lower16)) |-> !inside_mode)
    else $error("unordered limits did not select the outside window");

  // signed windows are written out apart from the comparator function
  a_inside_signed:
    assert property (accept && diff_mode && ($signed(upper16) < $signed(data16))
                     && ($signed(data16) < $signed(lower16)) |=> window_match_flag)
    else $error("signed word inside the window not flagged");

  a_outside_signed:
    assert property (accept && diff_mode && !($signed(upper16) < $signed(lower16))
                     && (($signed(data16) < $signed(lower16))
                     || ($signed(data16) > $signed(upper16))) |=> window_match_flag)
    else $error("signed word outside the window not flagged");

  // right-justified differential words carry the sign from bit 9 up through bit 15
  a_right_justify_sign:
    assert property (accept && !justify_select && diff_mode
                     |=> {st_q.word_high, st_q.word_low}
                         == 16'($signed($past(conv_in.word))))
    else $error("right-justified differential word not sign extended");

  a_refused_keeps_word:
    assert property (conv_refused |=> (st_q.word_high == $past(st_q.word_high))
                     && (st_q.word_low == $past(st_q.word_low)))
    else $error("refused result reached the word registers");

  a_upper_high_write:
    assert property (sfr_req.wr && (sfr_req.addr == window_pkg::ADDR_UPPER_HIGH)
                     |=> st_q.upper_high == $past(sfr_req.wdata))
    else $error("upper limit high byte write lost");

endmodule // window_detector

/* sim/conv_model.sv */
`timescale 1ns/1ps
// ============================================================
// converter result source: one done pulse per finished conversion
module conv_model
#(
  parameter int SPACING = 12
)
(
  // clock
  input wire logic core_clk,
  // result toward the detector
  output window_pkg::conv_in_s conv_in,
  // refusal seen at the detector
  input wire logic conv_refused
);
  // idle word starts at zero and is the inverted last word after each send, so a stale result is never mistaken for a fresh one
  initial conv_in = '0;
  // early skips the spacing wait, which only a refusal scenario asks for
  task automatic send(input logic [9:0] w, input bit early, output logic refused);
    if (!early)
      repeat (SPACING) @(posedge core_clk);
    @(posedge core_clk);
    conv_in <= '{done: 1'b1, word: w};
    #1 refused = conv_refused;
    @(posedge core_clk);
    conv_in <= '{done: 1'b0, word: ~w};
  endtask
endmodule // conv_model

/* sim/adc_window_detector_tb_top.sv */
`timescale 1ns/1ps
// ============================================================
// window detector bench
module adc_window_detector_tb_top;
  localparam int SPACING = 12;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  window_pkg::sfr_req_s sfr_req = '0;
  logic [7:0] sfr_rdata;
  window_pkg::conv_in_s conv_in;
  logic justify_select = 1'b0;
  logic [4:0] negative_input_select = 5'h1F;
  logic window_match_flag;
  logic conv_refused;
  logic refused;
  int bad_count = 0;
  int checks = 0;

  // 50 ns clock
  always #25 core_clk = ~core_clk;

  // ============================================================
  // instances
  window_detector #(.MIN_SPACING(SPACING)) window_detector_i (.core_clk(core_clk),
    .sys_rst(sys_rst), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .conv_in(conv_in),
    .justify_select(justify_select), .negative_input_select(negative_input_select),
    .window_match_flag(window_match_flag), .conv_refused(conv_refused));
  conv_model #(.SPACING(SPACING)) conv_model_i (.core_clk(core_clk), .conv_in(conv_in),
    .conv_refused(conv_refused));

  // ============================================================
  // compare and bus tasks
  task automatic check8(string n, logic [7:0] e, logic [7:0] g);
    checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic check1(string n, logic e, logic g);
    checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("ERROR %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge core_clk);
    sfr_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge core_clk);
    sfr_req.wr <= 1'b0;
  endtask
  // read data is registered on the strobe edge, so sample just after it
  task automatic rd_chk(string n, logic [7:0] a, logic [7:0] e);
    @(posedge core_clk);
    sfr_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge core_clk);
    sfr_req.rd <= 1'b0;
    #1 check8(n, e, sfr_rdata);
  endtask
  task automatic set_lim(logic [15:0] gt, logic [15:0] lt);
    wr(8'hC4, gt[15:8]);
    wr(8'hC3, gt[7:0]);
    wr(8'hC6, lt[15:8]);
    wr(8'hC5, lt[7:0]);
  endtask
  task automatic cv(logic [9:0] w, bit early, logic ef);
    conv_model_i.send(w, early, refused);
    #1 check1("refused", early, refused);
    check1("flag", ef, window_match_flag);
  endtask
  task automatic clr();
    wr(8'hE8, 8'h00);
  endtask

  // ============================================================
  // scenarios
  task automatic t_reset();
    rd_chk("upper_high", 8'hC4, 8'hFF);
    rd_chk("lower_high", 8'hC6, 8'h00);
    rd_chk("upper_low", 8'hC3, 8'hFF);
    rd_chk("control", 8'hE8, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_regs();
    wr(8'hC5, 8'h5A);
    rd_chk("lower_low", 8'hC5, 8'h5A);
    wr(8'hC3, 8'hA5);
    rd_chk("upper_low", 8'hC3, 8'hA5);
    rd_chk("unmapped", 8'h10, 8'h00);
    wr(8'hBE, 8'h33);
    rd_chk("word_high", 8'hBE, 8'h00);
    $display("test regs done");
  endtask
  task automatic t_inside();
    set_lim(16'h0040, 16'h0080);
    cv(10'h040, 0, 1'b0);
    cv(10'h080, 0, 1'b0);
    cv(10'h041, 0, 1'b1);
    cv(10'h000, 0, 1'b1);
    rd_chk("control", 8'hE8, 8'h08);
    clr();
    rd_chk("control", 8'hE8, 8'h00);
    $display("test inside done");
  endtask
  task automatic t_outside();
    set_lim(16'h0080, 16'h0040);
    cv(10'h060, 0, 1'b0);
    cv(10'h040, 0, 1'b0);
    cv(10'h03F, 0, 1'b1);
    clr();
    cv(10'h081, 0, 1'b1);
    clr();
    $display("test outside done");
  endtask
  task automatic t_diff();
    @(posedge core_clk);
    negative_input_select <= 5'h00;
    set_lim(16'hFFFF, 16'h0040);
    cv(10'h3FF, 0, 1'b0);
    rd_chk("word_high", 8'hBE, 8'hFF);
    rd_chk("word_low", 8'hBD, 8'hFF);
    cv(10'h000, 0, 1'b1);
    clr();
    set_lim(16'h0040, 16'hFFFF);
    cv(10'h3FE, 0, 1'b1);
    clr();
    @(posedge core_clk);
    justify_select <= 1'b1;
    cv(10'h3FF, 0, 1'b1);
    rd_chk("word_low", 8'hBD, 8'hC0);
    clr();
    @(posedge core_clk);
    justify_select <= 1'b0;
    negative_input_select <= 5'h1F;
    cv(10'h3FF, 0, 1'b1);
    rd_chk("word_high", 8'hBE, 8'h03);
    clr();
    $display("test differential done");
  endtask
  task automatic t_spacing();
    clr();
    cv(10'h3FF, 1, 1'b0);
    cv(10'h3FF, 0, 1'b1);
    clr();
    $display("test spacing done");
  endtask
  // a second reset in mid-run must bring the limits back to their reset values
  task automatic t_rerun();
    set_lim(16'h1234, 16'h5678);
    @(posedge core_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd_chk("upper_high", 8'hC4, 8'hFF);
    rd_chk("lower_high", 8'hC6, 8'h00);
    rd_chk("control", 8'hE8, 8'h00);
    $display("test reset again done");
  endtask

  // ============================================================
  // verdict, main sequence and hang guard
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_regs();
    t_inside();
    t_outside();
    t_diff();
    t_spacing();
    t_rerun();
    close_out();
  end
  initial
  begin
    #1000000;
    bad_count++;
    $display("ERROR watchdog expected done seen hang");
    close_out();
  end
endmodule // adc_window_detector_tb_top
